// File: dv/i2cb_bus_model.sv
`timescale 1ns/1ps
module i2cb_bus_model (
  // Design drive
  input  wire logic scl_oe_n,
  input  wire logic sda_oe_n,
  // Far-side controller and target pulls
  input  wire logic ext_scl_low,
  input  wire logic ext_sda_low,
  // Wire levels
  output logic      scl,
  output logic      sda
);
  // Open drain lines with pull-ups
  assign scl = scl_oe_n & ~ext_scl_low;
  assign sda = sda_oe_n & ~ext_sda_low;
endmodule // i2cb_bus_model

// File: dv/i2cb_timing_ctrl_asserts.sv
`timescale 1ns/1ps
module i2cb_timing_ctrl_asserts (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        arready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  // Bus side
  input wire logic        scl_oe_n,
  input wire logic        sda_oe_n,
  input wire logic        ctl_rx_valid,
  input wire logic        tgt_ready,
  input wire logic        bus_free,
  input wire logic        bus_recovering
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_bresp_stands: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  chk_rdata_stands: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  chk_ar_refused: assert property (rvalid |-> !arready)
    else $error("read address taken while answer pending");
  chk_rdata_upper: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  chk_scl_low_min: assert property (
    $fell(scl_oe_n) |-> !scl_oe_n [*8])
    else $error("scl low phase too short");
  chk_rx_single: assert property (ctl_rx_valid |=> !ctl_rx_valid)
    else $error("receive pulse longer than one cycle");
  chk_tgt_single: assert property (tgt_ready |=> !tgt_ready)
    else $error("target release pulse longer than one cycle");
  chk_free_released: assert property (
    bus_free |-> scl_oe_n && sda_oe_n)
    else $error("bus free while lines driven");
  chk_recov_sda: assert property (bus_recovering |-> sda_oe_n)
    else $error("sda driven during recovery");

  cov_write: cover property (bvalid && bready);
  cov_read: cover property (rvalid && rready);
  cov_recover: cover property ($rose(bus_recovering));
  cov_target: cover property (tgt_ready);
endmodule // i2cb_timing_ctrl_asserts

bind i2cb_timing_ctrl i2cb_timing_ctrl_asserts i2cb_timing_ctrl_asserts_inst (
  .aclk(aclk), .aresetn(aresetn), .arready(arready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .rdata(rdata), .rvalid(rvalid),
  .rready(rready), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n),
  .ctl_rx_valid(ctl_rx_valid), .tgt_ready(tgt_ready),
  .bus_free(bus_free), .bus_recovering(bus_recovering)
);

// File: dv/tb.sv
`timescale 1ns/1ps
module tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        ctl_bit_valid, ctl_bit_data, ctl_remote_ack;
  logic        tgt_valid, tgt_data, ext_scl_low, ext_sda_low;
  logic        awready, wready, bvalid, arready, rvalid, scl, sda;
  logic        scl_oe_n, sda_oe_n, ctl_bit_ready, ctl_rx_valid;
  logic        ctl_rx_data, tgt_ready, bus_free, bus_recovering;
  logic        scl_out, sda_out;
  int          error_cnt = 0;
  int          checks = 0;
  int          cyc = 0;
  int          mdl[4] = '{32'h1C, 32'h10, 32'h7A, 32'h7A};

  i2cb_timing_ctrl #(.WD_SLOW(200), .WD_FAST(40)) i2cb_timing_ctrl_inst (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .ctl_bit_valid(ctl_bit_valid), .ctl_bit_ready(ctl_bit_ready),
    .ctl_bit_data(ctl_bit_data), .ctl_remote_ack(ctl_remote_ack),
    .ctl_rx_valid(ctl_rx_valid), .ctl_rx_data(ctl_rx_data),
    .tgt_valid(tgt_valid), .tgt_ready(tgt_ready), .tgt_data(tgt_data),
    .bus_free(bus_free), .bus_recovering(bus_recovering));

  i2cb_bus_model i2cb_bus_model_inst (
    .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .ext_scl_low(ext_scl_low),
    .ext_sda_low(ext_sda_low), .scl(scl), .sda(sda));

  always #5 aclk = ~aclk;

  task automatic conclude;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk("bresp", bresp, (a[7:4] == 4'h2 && a[1:0] == 2'h0) ? 0 : 2);
    bready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    chk("rdata", rdata, e);
    chk("rresp", rresp, r);
    rready <= 1'b0;
  endtask

  // One controller bit: low, data change point and high lengths
  task automatic bit_tx(input logic b, ra, output int nlo, nsd, nhi);
    logic s0;
    @(posedge aclk);
    ctl_bit_valid <= 1'b1;
    ctl_bit_data <= b;
    ctl_remote_ack <= ra;
    do @(posedge aclk); while (ctl_bit_ready !== 1'b1);
    ctl_bit_valid <= 1'b0;
    s0 = sda_oe_n;
    nlo = 0;
    nsd = 0;
    nhi = 0;
    @(posedge aclk);
    while (scl_oe_n === 1'b0 && nlo < 500) begin
      if (nsd == 0 && sda_oe_n !== s0) nsd = nlo;
      nlo++;
      @(posedge aclk);
    end
    while (ctl_rx_valid !== 1'b1 && nhi < 500) begin
      @(posedge aclk);
      nhi++;
    end
    chk("rx_data", ctl_rx_data, b);
  endtask

  task automatic wait_flag(ref logic f, output int n);
    n = 0;
    while (f !== 1'b1 && n < 1000) begin
      @(posedge aclk);
      n++;
    end
  endtask

  initial begin
    int lo, sd, hi, n, hc, dl, v;
    logic p;
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {ctl_bit_valid, ctl_remote_ack, tgt_valid, ext_scl_low} = '0;
    {ctl_bit_data, tgt_data, ext_sda_low} = 3'b110;
    void'($urandom(32'h2FD68022));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++)
      rd_chk(8'((8 + i) * 4), mdl[i], 0);
    for (int k = 0; k < 12; k++) begin
      v = $urandom;
      wr(8'((8 + k % 4) * 4), v);
      mdl[k % 4] = v & (k % 4 == 0 ? 32'h7F : 32'hFF);
      rd_chk(8'((8 + k % 4) * 4), mdl[k % 4], 0);
    end
    wr(8'h30, 32'h55);
    rd_chk(8'h30, 0, 2);
    rd_chk(8'h21, 0, 2);
    // Short counts with margin for the oscillator spread
    wr(8'h2C, 32'h6);
    hi = $urandom_range(3, 0);
    wr(8'h28, hi);
    wr(8'h20, 32'h10);
    for (int d = 0; d < 4; d++) begin
      wr(8'h24, d << 2);
      bit_tx(d[0], 1'b0, lo, sd, n);
      dl = 24 + 4 * d;
      chk("scl_low", lo, 40);
      chk("sda_delay", sd >= dl - 1 && sd <= dl + 1, 1);
      chk("scl_high", n >= 4 * (hi + 4) && n <= 4 * (hi + 4) + 4, 1);
    end
    for (int s = 0; s < 2; s++) begin
      wr(8'h24, (s << 4) | 12);
      bit_tx(s[0], 1'b1, lo, sd, n);
      dl = 45 + 64 * s;
      chk("ack_setup", lo >= dl - 2 && lo <= dl + 2, 1);
    end
    wait_flag(bus_free, n);
    chk("free_slow", n >= 190 && n <= 220, 1);
    rd_chk(8'h40, 32'h1, 0);
    wr(8'h24, 32'h02);
    bit_tx(1'b1, 1'b0, lo, sd, hi);
    wait_flag(bus_free, n);
    chk("free_fast", n >= 30 && n <= 60, 1);
    ext_sda_low <= 1'b1;
    wait_flag(bus_recovering, n);
    chk("hung_seen", n <= 70, 1);
    ext_sda_low <= 1'b0;
    hc = 0;
    n = 0;
    p = scl_oe_n;
    while (bus_recovering === 1'b1 && n < 5000) begin
      @(posedge aclk);
      if (p === 1'b1 && scl_oe_n === 1'b0) hc++;
      p = scl_oe_n;
      n++;
    end
    chk("recovery_clocks", hc, 9);
    wait_flag(bus_free, n);
    chk("free_after", bus_free, 1);
    ext_scl_low <= 1'b1;
    repeat (4) @(posedge aclk);
    tgt_valid <= 1'b1;
    tgt_data <= 1'b0;
    n = 0;
    while (scl_oe_n !== 1'b0 && n < 100) begin
      @(posedge aclk);
      n++;
    end
    ext_scl_low <= 1'b0;
    n = 0;
    while (scl_oe_n === 1'b0 && n < 500) begin
      @(posedge aclk);
      n++;
    end
    chk("tgt_low", n >= 38 && n <= 42, 1);
    chk("tgt_ready", tgt_ready, 1);
    chk("tgt_sda", sda_oe_n, 0);
    tgt_valid <= 1'b0;
    ext_scl_low <= 1'b1;
    repeat (3) @(posedge aclk);
    ext_scl_low <= 1'b0;
    wr(8'h24, 32'h03);
    ext_sda_low <= 1'b1;
    v = 0;
    repeat (300) begin
      @(posedge aclk);
      if (bus_recovering !== 1'b0 || bus_free !== 1'b0) v = 1;
    end
    chk("wd_disabled", v, 0);
    chk("pin_out", {scl_out, sda_out}, 2'h0);
    conclude();
  end
endmodule // tb

// File: rtl/i2cb_cfg.svh
`ifndef I2CB_CFG_SVH
`define I2CB_CFG_SVH
// Register indexes, byte address is four times the index
`define I2CB_IDX_ITIM   8'h08
`define I2CB_IDX_OTIM   8'h09
`define I2CB_IDX_SCLHI  8'h0A
`define I2CB_IDX_SCLLO  8'h0B
`define I2CB_IDX_STAT   8'h10
// Reset values
`define I2CB_RST_HOLD   3'h1
`define I2CB_RST_FILT   4'hC
`define I2CB_RST_SETUP  4'h1
`define I2CB_RST_DLY    2'h0
`define I2CB_RST_SCLHI  8'h7A
`define I2CB_RST_SCLLO  8'h7A
// Timing, in ns unless named otherwise; I2CB_SCL_EXTRA counts oscillator periods
`define I2CB_CLK_NS     10
`define I2CB_OSC_NS     40
`define I2CB_SCL_EXTRA  4
`define I2CB_HOLD_NS    50
`define I2CB_FILT_NS    5
`define I2CB_SETUP0_NS  80
`define I2CB_SETUPS_NS  640
`define I2CB_DLY0_NS    240
`define I2CB_DLYS_NS    40
`define I2CB_WD_SLOW_US 1000000
`define I2CB_WD_FAST_US 50
`define I2CB_RECOV_BITS 9
// AXI responses
`define I2CB_RESP_OKAY  2'h0
`define I2CB_RESP_SLV   2'h2
`endif

// File: rtl/i2cb_glitch.sv
`timescale 1ns/1ps
module i2cb_glitch #(
  parameter int CW = 4
) (
  // Clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          ce,
  // Line
  input  wire logic          din,
  input  wire logic [CW-1:0] thr,
  output logic               dout
);
  logic [CW-1:0] cnt;

  // Output follows only after the input differs for more than thr cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dout <= 1'b1;
      cnt  <= '0;
    end else if (ce) begin
      if (din == dout) begin
        cnt <= '0;
      end else if (cnt >= thr) begin
        dout <= din;
        cnt  <= '0;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end
endmodule // i2cb_glitch

// File: rtl/i2cb_pkg.sv
package i2cb_pkg;
  typedef struct packed {
    logic       rsv;
    logic [2:0] hold;
    logic [3:0] filt;
  } i2cb_itim_s;

  typedef struct packed {
    logic [3:0] setup;
    logic [1:0] dly;
    logic       fast;
    logic       wd_dis;
  } i2cb_otim_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOW,
    ST_HIGH,
    ST_TGT
  } i2cb_state_e;

  typedef enum logic [2:0] {
    RS_NONE,
    RS_ITIM,
    RS_OTIM,
    RS_SCLHI,
    RS_SCLLO,
    RS_STAT
  } i2cb_reg_e;
endpackage

// File: rtl/i2cb_timing_ctrl.sv
`timescale 1ns/1ps
`include "i2cb_cfg.svh"
module i2cb_timing_ctrl
  import i2cb_pkg::*;
#(
  parameter int ADDR_W  = 8,
  parameter int WD_SLOW = `I2CB_WD_SLOW_US * 1000 / `I2CB_CLK_NS,
  parameter int WD_FAST = `I2CB_WD_FAST_US * 1000 / `I2CB_CLK_NS
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // I2C pins
  input  wire logic              scl_in,
  output logic                   scl_out,
  output logic                   scl_oe_n,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe_n,
  // Controller bit port
  input  wire logic              ctl_bit_valid,
  output logic                   ctl_bit_ready,
  input  wire logic              ctl_bit_data,
  input  wire logic              ctl_remote_ack,
  output logic                   ctl_rx_valid,
  output logic                   ctl_rx_data,
  // Target stretch port
  input  wire logic              tgt_valid,
  output logic                   tgt_ready,
  input  wire logic              tgt_data,
  // Bus state
  output logic                   bus_free,
  output logic                   bus_recovering
);
  localparam int HOLD_TAPS = 7 * `I2CB_HOLD_NS / `I2CB_CLK_NS;

  i2cb_itim_s    itim;
  i2cb_otim_s    otim;
  logic [7:0]    scl_hi;
  logic [7:0]    scl_lo;
  i2cb_itim_s    sh_itim;
  i2cb_otim_s    sh_otim;
  logic [7:0]    sh_hi;
  logic [7:0]    sh_lo;

  logic              aw_got;
  logic              w_got;
  logic [ADDR_W-1:0] aw_a;
  logic [7:0]        w_d;
  logic              w_be;

  i2cb_state_e   state;
  logic [15:0]   cnt;
  logic [15:0]   scnt;
  logic          sda_set;
  logic          bit_q;
  logic          remote_q;
  logic [3:0]    rec_left;
  logic          rec_q;
  logic          sda_drv;
  logic          tgt_hold;

  logic          scl_f;
  logic          sda_f;
  logic          scl_fq;
  logic [HOLD_TAPS-1:0] sda_dl;
  logic          sda_h;
  logic          hung;

  logic [15:0]   lo_cyc;
  logic [15:0]   hi_cyc;
  logic [15:0]   dly_cyc;
  logic [15:0]   set_cyc;
  logic [5:0]    hold_cyc;
  logic          end_hi;
  logic          next_bit;

  function automatic i2cb_reg_e reg_sel(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-3:0] ix;
    ix = a[ADDR_W-1:2];
    if (a[1:0] != 2'h0)
      reg_sel = RS_NONE;
    else if (ix == (ADDR_W-2)'(`I2CB_IDX_ITIM))
      reg_sel = RS_ITIM;
    else if (ix == (ADDR_W-2)'(`I2CB_IDX_OTIM))
      reg_sel = RS_OTIM;
    else if (ix == (ADDR_W-2)'(`I2CB_IDX_SCLHI))
      reg_sel = RS_SCLHI;
    else if (ix == (ADDR_W-2)'(`I2CB_IDX_SCLLO))
      reg_sel = RS_SCLLO;
    else if (ix == (ADDR_W-2)'(`I2CB_IDX_STAT))
      reg_sel = RS_STAT;
    else
      reg_sel = RS_NONE;
  endfunction

  // AXI4-Lite slave
  assign awready = ce & ~aw_got;
  assign wready  = ce & ~w_got;
  assign arready = ce & ~rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got  <= 1'b0;
      aw_a   <= '0;
      w_d    <= 8'h00;
      w_be   <= 1'b0;
      bvalid <= 1'b0;
      bresp  <= `I2CB_RESP_OKAY;
      itim   <= '{1'b0, `I2CB_RST_HOLD, `I2CB_RST_FILT};
      otim   <= '{`I2CB_RST_SETUP, `I2CB_RST_DLY, 1'b0, 1'b0};
      scl_hi <= `I2CB_RST_SCLHI;
      scl_lo <= `I2CB_RST_SCLLO;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_got <= 1'b1;
        aw_a   <= awaddr;
      end
      if (wvalid && wready) begin
        w_got <= 1'b1;
        w_d   <= wdata[7:0];
        w_be  <= wstrb[0];
      end
      if (bvalid && bready)
        bvalid <= 1'b0;
      if (aw_got && w_got && !bvalid) begin
        aw_got <= 1'b0;
        w_got  <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= `I2CB_RESP_OKAY;
        case (reg_sel(aw_a))
          RS_ITIM:  if (w_be) itim <= {1'b0, w_d[6:0]};
          RS_OTIM:  if (w_be) otim <= w_d;
          RS_SCLHI: if (w_be) scl_hi <= w_d;
          RS_SCLLO: if (w_be) scl_lo <= w_d;
          RS_STAT:  ;
          default:  bresp <= `I2CB_RESP_SLV;
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= `I2CB_RESP_OKAY;
    end else if (ce) begin
      if (rvalid && rready)
        rvalid <= 1'b0;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp  <= `I2CB_RESP_OKAY;
        rdata  <= 32'h0;
        case (reg_sel(araddr))
          RS_ITIM:  rdata[7:0] <= itim;
          RS_OTIM:  rdata[7:0] <= otim;
          RS_SCLHI: rdata[7:0] <= scl_hi;
          RS_SCLLO: rdata[7:0] <= scl_lo;
          RS_STAT:  rdata[2:0] <= {state != ST_IDLE, bus_recovering,
                                   bus_free};
          default:  rresp <= `I2CB_RESP_SLV;
        endcase
      end
    end
  end

  // Working copies only reload while the bit engine is idle; back-to-back bits go from ST_HIGH to ST_LOW without a reload
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh_itim <= '{1'b0, `I2CB_RST_HOLD, `I2CB_RST_FILT};
      sh_otim <= '{`I2CB_RST_SETUP, `I2CB_RST_DLY, 1'b0, 1'b0};
      sh_hi   <= `I2CB_RST_SCLHI;
      sh_lo   <= `I2CB_RST_SCLLO;
    end else if (ce && state == ST_IDLE) begin
      sh_itim <= itim;
      sh_otim <= otim;
      sh_hi   <= scl_hi;
      sh_lo   <= scl_lo;
    end
  end

  // Phase lengths in clock cycles
  assign hi_cyc = 16'((16'(sh_hi) + 16'(`I2CB_SCL_EXTRA))
                  * 16'(`I2CB_OSC_NS / `I2CB_CLK_NS));
  assign lo_cyc = 16'((16'(sh_lo) + 16'(`I2CB_SCL_EXTRA))
                  * 16'(`I2CB_OSC_NS / `I2CB_CLK_NS));
  assign dly_cyc = 16'((`I2CB_DLY0_NS + `I2CB_DLYS_NS
                   * int'(sh_otim.dly)) / `I2CB_CLK_NS);
  assign set_cyc = 16'((`I2CB_SETUP0_NS + `I2CB_SETUPS_NS
                   * int'(sh_otim.setup)) / `I2CB_CLK_NS);
  assign hold_cyc = 6'(int'(sh_itim.hold) * `I2CB_HOLD_NS
                    / `I2CB_CLK_NS);

  // Input conditioning
  i2cb_glitch #(
    .CW (3)
  ) u_scl_flt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .din     (scl_in),
    .thr     (sh_itim.filt[3:1]),
    .dout    (scl_f)
  );

  i2cb_glitch #(
    .CW (3)
  ) u_sda_flt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .din     (sda_in),
    .thr     (sh_itim.filt[3:1]),
    .dout    (sda_f)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sda_dl <= '1;
      scl_fq <= 1'b1;
    end else if (ce) begin
      sda_dl <= {sda_dl[HOLD_TAPS-2:0], sda_f};
      scl_fq <= scl_f;
    end
  end

  assign sda_h = (hold_cyc == 6'h0) ? sda_f
               : sda_dl[hold_cyc - 6'h1];

  // Pending requests count as activity, so free clears as SCL is taken
  i2cb_watchdog #(
    .TO_SLOW (WD_SLOW),
    .TO_FAST (WD_FAST)
  ) u_wd (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .scl      (scl_f),
    .sda      (sda_f),
    .busy     ((state != ST_IDLE) || ctl_bit_valid || tgt_valid),
    .dis      (sh_otim.wd_dis),
    .fast     (sh_otim.fast),
    .bus_free (bus_free),
    .hung     (hung)
  );

  // Bit engine
  assign end_hi = (state == ST_HIGH) && scl_f && (cnt >= hi_cyc - 16'h1);
  assign next_bit = (state == ST_IDLE) || end_hi;
  assign ctl_bit_ready = ce && next_bit && (rec_left == 4'h0) && !hung;
  assign bus_recovering = (rec_left != 4'h0);
  assign scl_out  = 1'b0;
  assign sda_out  = 1'b0;
  assign scl_oe_n = ~((state == ST_LOW) || (state == ST_TGT));
  assign sda_oe_n = ~sda_drv;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state        <= ST_IDLE;
      cnt          <= 16'h0;
      scnt         <= 16'h0;
      sda_set      <= 1'b0;
      bit_q        <= 1'b1;
      remote_q     <= 1'b0;
      rec_left     <= 4'h0;
      rec_q        <= 1'b0;
      sda_drv      <= 1'b0;
      tgt_hold     <= 1'b0;
      tgt_ready    <= 1'b0;
      ctl_rx_valid <= 1'b0;
      ctl_rx_data  <= 1'b1;
    end else if (ce) begin
      tgt_ready    <= 1'b0;
      ctl_rx_valid <= 1'b0;
      if (hung && state == ST_IDLE) begin
        rec_left <= 4'(`I2CB_RECOV_BITS);
        sda_drv  <= 1'b0;
      end
      if (tgt_hold && scl_fq && !scl_f) begin
        tgt_hold <= 1'b0;
        sda_drv  <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          cnt <= 16'h0;
        end
        ST_LOW: begin
          cnt <= cnt + 16'h1;
          if (sda_set)
            scnt <= scnt + 16'h1;
          if (!sda_set && cnt >= dly_cyc - 16'h1) begin
            sda_set <= 1'b1;
            sda_drv <= ~bit_q;
          end
          if (sda_set && cnt >= lo_cyc - 16'h1 &&
              (!remote_q || scnt >= set_cyc - 16'h1)) begin
            state <= ST_HIGH;
            cnt   <= 16'h0;
          end
        end
        ST_HIGH: begin
          if (scl_f)
            cnt <= cnt + 16'h1;
          if (end_hi) begin
            ctl_rx_valid <= !rec_q;
            ctl_rx_data  <= sda_h;
            state        <= ST_IDLE;
          end
        end
        ST_TGT: begin
          cnt <= cnt + 16'h1;
          if (cnt >= lo_cyc - 16'h1) begin
            state     <= ST_IDLE;
            tgt_ready <= 1'b1;
            tgt_hold  <= 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
      if (next_bit) begin
        if (rec_left != 4'h0) begin
          rec_left <= rec_left - 4'h1;
          rec_q    <= 1'b1;
          bit_q    <= 1'b1;
          remote_q <= 1'b0;
          state    <= ST_LOW;
          cnt      <= 16'h0;
          scnt     <= 16'h0;
          sda_set  <= 1'b0;
        end else if (ctl_bit_valid && !hung) begin
          bit_q    <= ctl_bit_data;
          remote_q <= ctl_remote_ack;
          rec_q    <= 1'b0;
          state    <= ST_LOW;
          cnt      <= 16'h0;
          scnt     <= 16'h0;
          sda_set  <= 1'b0;
        // The ready edge consumes the request; filtered SCL still lags
        end else if (state == ST_IDLE && tgt_valid && !tgt_ready &&
                     !scl_f) begin
          state    <= ST_TGT;
          cnt      <= 16'h0;
          sda_drv  <= ~tgt_data;
          tgt_hold <= 1'b0;
        end
      end
    end
  end
endmodule // i2cb_timing_ctrl

// File: rtl/i2cb_watchdog.sv
`timescale 1ns/1ps
module i2cb_watchdog #(
  parameter int TO_SLOW = 100000000,
  parameter int TO_FAST = 5000
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  // Bus view
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic busy,
  // Control
  input  wire logic dis,
  input  wire logic fast,
  // Result
  output logic      bus_free,
  output logic      hung
);
  logic [31:0] cnt;
  logic [31:0] lim;
  logic        scl_q;
  logic        sda_q;
  logic        done;
  logic        act;

  assign lim = fast ? 32'(TO_FAST) : 32'(TO_SLOW);
  assign act = (scl != scl_q) || (sda != sda_q) || busy;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce) begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt      <= '0;
      done     <= 1'b0;
      bus_free <= 1'b0;
      hung     <= 1'b0;
    end else if (ce) begin
      hung <= 1'b0;
      if (dis || act) begin
        cnt      <= '0;
        done     <= 1'b0;
        bus_free <= 1'b0;
      end else if (!done) begin
        if (cnt >= lim - 32'd1) begin
          done <= 1'b1;
          if (sda) begin
            bus_free <= 1'b1;
          end else begin
            hung <= 1'b1;
          end
        end else begin
          cnt <= cnt + 32'd1;
        end
      end
    end
  end
endmodule // i2cb_watchdog
